// File: verilog/hbridge_map.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef HBRIDGE_MAP_SVH
`define HBRIDGE_MAP_SVH
`define ALIGN_SELECT_OFS      8'h00
`define GATE_CONTROL_OFS      8'h04
`define DEADTIME_CONFIG_OFS   8'h08
`define OUTPUT_POLARITY_OFS   8'h0c
`define HV_DRIVER_CONTROL_OFS 8'h10
`define THERMAL_IRQ_OFS       8'h14
`define CTRL_RESET_VALUE      8'h00
`define NIBBLE_MASK           8'h0f
`define HV_WRITE_MASK         8'h3b
`define DT_DIV_MSB            7
`define DT_DIV_LSB            6
`define DT_ENABLE_BIT         5
`define DT_COUNT_MSB          4
`define HV_DRIVER_ENABLE_BIT  4
`define HV_THERMAL_GUARD_BIT  3
`define HV_OVERTEMP_BIT       2
`define IRQ_FLAG_BIT          0
`define IRQ_ENABLE_BIT        1
`endif

// File: verilog/hbridge_pkg.sv
// Purpose: Shared types of the H-bridge output control
// Assumes: Used only by scoped names
// Notes:   Offsets and fields live in hbridge_map.svh
package hbridge_pkg;
  typedef struct packed {
    logic top;
    logic bottom;
  } gate_pair_type;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_type;

  typedef enum {
    WR_COLLECT,
    WR_RESPOND
  } write_state_type;
endpackage

// File: verilog/hbridge_output_control.sv
// Purpose: Two-channel complementary gate drive with dead-time
// Assumes: timer1_pwm comes from logic on aclk; overtemp_pin is async
// Notes:   Register slave on AXI4-Lite, 8-bit registers in low byte
`timescale 1ns/1ps
`include "hbridge_map.svh"

// Function
// RULE_01: Two channels: align, then dead-time, then guard, then polarity.
// RULE_02: Align field bits 3:2 steer channel 1, bits 1:0 channel 0.
// RULE_03: Align 00: top follows pwm, bottom its inverse.
// RULE_04: Align 01: top follows pwm, bottom held low.
// RULE_05: Align 10: top held low, bottom follows pwm.
// RULE_06: Align 11: top and bottom follow the manual gate bits.
// RULE_07: Manual pair 00 off, 01 bottom, 10 top, 11 both off.
// RULE_08: Dead-time clock is system clock divided by 1, 2, 4 or 8.
// RULE_09: Dead-time only when its enable bit is set, else pass through.
// RULE_10: Dead-time lasts count plus one dead-time clock periods.
// RULE_11: Only rising edges are delayed; falling edges pass at once.
// RULE_12: Software should keep dead-time within 0.3 to 5 microseconds.
// RULE_13: Guard forces both outputs low when both inputs are high.
// RULE_14: Each of four gate outputs has its own invert bit.
// RULE_15: Both channels use timer 1 pwm and its complement.
// RULE_16: Driver enable low turns the whole output stage off.
// RULE_17: Software sets guard before driver, clears guard before driver.
// RULE_18: Overtemp flag reads one while overtemperature is present; code reads one only while the guard bit is also set.
// RULE_19: Rising overtemp sets the irq flag; irq raised when enabled.
// RULE_20: A path falling mid count stays low; count restarts next rise.
// RULE_21: Control registers reset to zero; upper bits read zero.
module hbridge_output_control (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [7:0]                      s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [7:0]                      s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            timer1_pwm,
  input  wire logic                            overtemp_pin,
  output hbridge_pkg::gate_pair_type [1:0]     gates_q,
  output logic                                 hv_driver_on_q,
  output logic                                 thermal_irq_q
);

  // Control registers
  logic [7:0] align_mode_select_q;
  logic [7:0] manual_gate_bits_q;
  logic [7:0] deadtime_config_reg_q;
  logic [7:0] gate_polarity_select_q;
  logic [7:0] hv_driver_ctl_q;
  logic       thermal_irq_flag_q;
  logic       thermal_irq_enable_q;

  // Bus side state
  hbridge_pkg::write_state_type wr_state_q;
  logic [7:0]  wr_addr_q;
  logic [7:0]  wr_data_q;
  logic        wr_strb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        wr_fire;
  logic        wr_hit;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  // Signal path
  logic        overtemp_meta_q;
  logic        overtemp_sync_q;
  logic        overtemp_prev_q;
  logic        overtemp_now;
  logic        timer1_pwm_inverted;
  logic [3:0]  aligned;
  wire  [3:0]  delayed_q;
  logic [3:0]  guarded;
  logic [3:0]  polarized;
  logic [2:0]  div_q;
  logic [2:0]  div_mask;
  logic        dt_tick;
  logic        dt_enable;
  logic [4:0]  dt_count;
  logic        hv_driver_enable;
  logic        thermal_guard_enable;

  assign dt_enable            = deadtime_config_reg_q[`DT_ENABLE_BIT];
  assign dt_count             = deadtime_config_reg_q[`DT_COUNT_MSB:0];
  assign hv_driver_enable     = hv_driver_ctl_q[`HV_DRIVER_ENABLE_BIT];
  assign thermal_guard_enable = hv_driver_ctl_q[`HV_THERMAL_GUARD_BIT];

  // Overtemp pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overtemp_meta_q <= 1'b0;
      overtemp_sync_q <= 1'b0;
    end else begin
      overtemp_meta_q <= overtemp_pin;
      overtemp_sync_q <= overtemp_meta_q;
    end
  end

  // Flag only meaningful while thermal protection is on
  assign overtemp_now = overtemp_sync_q & thermal_guard_enable; // [RULE_18]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overtemp_prev_q <= 1'b0;
    end else begin
      overtemp_prev_q <= overtemp_now;
    end
  end

  // Thermal irq flag, set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_irq_flag_q <= 1'b0;
    end else if (overtemp_now && !overtemp_prev_q) begin
      thermal_irq_flag_q <= 1'b1; // [RULE_19]
    end else if (wr_fire && wr_hit && wr_strb_q &&
                 wr_addr_q == `THERMAL_IRQ_OFS &&
                 wr_data_q[`IRQ_FLAG_BIT]) begin
      thermal_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_irq_q <= 1'b0;
    end else begin
      thermal_irq_q <= thermal_irq_flag_q & thermal_irq_enable_q; // [RULE_19]
    end
  end

  // Write address and data collection, either order
  assign wr_fire = (wr_state_q == hbridge_pkg::WR_COLLECT) &&
                   aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr_q     <= 8'h00;
      wr_data_q     <= 8'h00;
      wr_strb_q     <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready)
                       && !wr_fire;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready)
                       && !wr_fire;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q  <= 1'b1;
        wr_data_q <= s_axi_wdata[7:0];
        wr_strb_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  assign wr_hit = (wr_addr_q[1:0] == 2'b00) &&
                  (wr_addr_q <= `THERMAL_IRQ_OFS);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q   <= hbridge_pkg::WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hbridge_pkg::RESP_OKAY;
    end else begin
      case (wr_state_q)
        hbridge_pkg::WR_COLLECT: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? hbridge_pkg::RESP_OKAY
                                   : hbridge_pkg::RESP_SLVERR;
            wr_state_q   <= hbridge_pkg::WR_RESPOND;
          end
        end
        hbridge_pkg::WR_RESPOND: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_q   <= hbridge_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_q <= hbridge_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  // Register writes; unused bits kept at zero, except driver control bits 5, 1 and 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_mode_select_q    <= `CTRL_RESET_VALUE; // [RULE_21]
      manual_gate_bits_q     <= `CTRL_RESET_VALUE;
      deadtime_config_reg_q  <= `CTRL_RESET_VALUE;
      gate_polarity_select_q <= `CTRL_RESET_VALUE;
      hv_driver_ctl_q        <= `CTRL_RESET_VALUE;
      thermal_irq_enable_q   <= 1'b0;
    end else if (wr_fire && wr_hit && wr_strb_q) begin
      case (wr_addr_q)
        `ALIGN_SELECT_OFS:
          align_mode_select_q <= wr_data_q & `NIBBLE_MASK; // [RULE_21]
        `GATE_CONTROL_OFS:
          manual_gate_bits_q <= wr_data_q & `NIBBLE_MASK;
        `DEADTIME_CONFIG_OFS:
          deadtime_config_reg_q <= wr_data_q;
        `OUTPUT_POLARITY_OFS:
          gate_polarity_select_q <= wr_data_q & `NIBBLE_MASK;
        `HV_DRIVER_CONTROL_OFS:
          hv_driver_ctl_q <= wr_data_q & `HV_WRITE_MASK;
        `THERMAL_IRQ_OFS:
          thermal_irq_enable_q <= wr_data_q[`IRQ_ENABLE_BIT];
        default: begin
        end
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `ALIGN_SELECT_OFS:      rd_byte = align_mode_select_q;
      `GATE_CONTROL_OFS:      rd_byte = manual_gate_bits_q;
      `DEADTIME_CONFIG_OFS:   rd_byte = deadtime_config_reg_q;
      `OUTPUT_POLARITY_OFS:   rd_byte = gate_polarity_select_q;
      `HV_DRIVER_CONTROL_OFS: begin
        rd_byte = hv_driver_ctl_q;
        rd_byte[`HV_OVERTEMP_BIT] = overtemp_now; // [RULE_18]
      end
      `THERMAL_IRQ_OFS: begin
        rd_byte[`IRQ_FLAG_BIT]   = thermal_irq_flag_q;
        rd_byte[`IRQ_ENABLE_BIT] = thermal_irq_enable_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= hbridge_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? hbridge_pkg::RESP_OKAY
                              : hbridge_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  assign timer1_pwm_inverted = ~timer1_pwm; // [RULE_15]

  // Align stage, path 2n+1 is top and 2n is bottom of channel n
  always_comb begin
    aligned = 4'h0;
    for (int n = 0; n < 2; n++) begin
      case (align_mode_select_q[2*n +: 2]) // [RULE_02]
        2'b00: begin
          aligned[2*n+1] = timer1_pwm; // [RULE_03]
          aligned[2*n]   = timer1_pwm_inverted;
        end
        2'b01: begin
          aligned[2*n+1] = timer1_pwm; // [RULE_04]
          aligned[2*n]   = 1'b0;
        end
        2'b10: begin
          aligned[2*n+1] = 1'b0; // [RULE_05]
          aligned[2*n]   = timer1_pwm;
        end
        default: begin
          // Manual pair; both bits set means both off
          aligned[2*n+1] = manual_gate_bits_q[2*n+1] &
                           !manual_gate_bits_q[2*n]; // [RULE_06] [RULE_07]
          aligned[2*n]   = manual_gate_bits_q[2*n] &
                           !manual_gate_bits_q[2*n+1];
        end
      endcase
    end
  end

  // Dead-time clock enable divider
  always_comb begin
    case (deadtime_config_reg_q[`DT_DIV_MSB:`DT_DIV_LSB])
      2'b00:   div_mask = 3'h0; // [RULE_08]
      2'b01:   div_mask = 3'h1;
      2'b10:   div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  assign dt_tick = (div_q & div_mask) == div_mask;

  // Dead-time stage, one counter per gate path
  for (genvar p = 0; p < 4; p++) begin : g_deadtime
    logic [4:0] cnt_q;
    logic       dly_q;
    assign delayed_q[p] = dly_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q <= 5'h00;
        dly_q <= 1'b0;
      end else if (!dt_enable) begin
        cnt_q <= 5'h00; // [RULE_09]
        dly_q <= aligned[p];
      end else if (!aligned[p]) begin
        cnt_q <= 5'h00; // [RULE_11] [RULE_20]
        dly_q <= 1'b0;
      end else if (!dly_q && dt_tick) begin
        if (cnt_q == dt_count) begin
          dly_q <= 1'b1; // [RULE_10]
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // Guard and polarity stages
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      guarded[2*n+1] = delayed_q[2*n+1] & !delayed_q[2*n]; // [RULE_13]
      guarded[2*n]   = delayed_q[2*n] & !delayed_q[2*n+1];
    end
    polarized = guarded ^ gate_polarity_select_q[3:0]; // [RULE_14]
  end

  // Driver output stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gates_q        <= 4'h0;
      hv_driver_on_q <= 1'b0;
    end else begin
      gates_q        <= hv_driver_enable ? polarized : 4'h0; // [RULE_16] [RULE_01]
      hv_driver_on_q <= hv_driver_enable;
    end
  end

  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_guard_exclusive;
    hv_driver_enable && gate_polarity_select_q == 8'h00
      |=> !(gates_q[0].top && gates_q[0].bottom) &&
          !(gates_q[1].top && gates_q[1].bottom);
  endproperty
  a_guard_exclusive: assert property (p_guard_exclusive) // [RULE_13]
    else $error("both gates of a channel on");

  property p_driver_off;
    !hv_driver_enable |=> gates_q == 4'h0;
  endproperty
  a_driver_off: assert property (p_driver_off) // [RULE_16]
    else $error("gate driven while driver off");

  property p_dt_bypass;
    aresetn && !dt_enable |=> delayed_q == $past(aligned);
  endproperty
  a_dt_bypass: assert property (p_dt_bypass) // [RULE_09]
    else $error("dead-time stage not transparent");

  property p_fall_immediate;
    dt_enable && !aligned[0] |=> !delayed_q[0];
  endproperty
  a_fall_immediate: assert property (p_fall_immediate) // [RULE_11]
    else $error("falling edge delayed");

  property p_rise_delayed;
    dt_enable && !delayed_q[1] && aligned[1] && !dt_tick |=> !delayed_q[1];
  endproperty
  a_rise_delayed: assert property (p_rise_delayed) // [RULE_10]
    else $error("rising edge not held for dead-time");

  property p_irq_set;
    overtemp_now && !overtemp_prev_q |=> thermal_irq_flag_q;
  endproperty
  a_irq_set: assert property (p_irq_set) // [RULE_19]
    else $error("thermal irq flag missed");

  property p_irq_out;
    thermal_irq_flag_q && thermal_irq_enable_q |=> thermal_irq_q;
  endproperty
  a_irq_out: assert property (p_irq_out) // [RULE_19]
    else $error("thermal irq not raised");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped");

  property p_upper_zero;
    s_axi_arvalid && s_axi_arready
      |=> s_axi_rdata[31:8] == 24'h000000 &&
          (s_axi_rdata[7:6] == 2'b00 ||
           $past(s_axi_araddr) == `DEADTIME_CONFIG_OFS);
  endproperty
  a_upper_zero: assert property (p_upper_zero) // [RULE_21]
    else $error("unimplemented bits read nonzero");
endmodule

// File: sim/gate_load_model.sv
// Purpose: Load model of the four external power switch gates
// Assumes: Bench mirrors the polarity register on the invert input
// Notes:   Counts cycles in which both switches of one leg conduct while hv_on is high
`timescale 1ns/1ps
module gate_load_model (
  input  wire logic                            aclk,
  input  wire hbridge_pkg::gate_pair_type [1:0] gates,
  input  wire logic [3:0]                      invert,
  input  wire logic                            hv_on,
  output int                                   overlap_count
);
  logic [3:0] conducting;

  // Undo output polarity to get the switch states
  assign conducting = gates ^ invert;

  // A shorted leg only matters while the driver stage is powered
  initial overlap_count = 0;
  always @(posedge aclk) begin
    if (hv_on && ((&conducting[3:2]) || (&conducting[1:0]))) begin
      overlap_count <= overlap_count + 1;
    end
  end
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the H-bridge output control
// Assumes: Register slave answers with the hand-over timing
// Notes:   Dead-time windows allow for the free-running divider phase
`timescale 1ns/1ps
`include "hbridge_map.svh"
module tb_top;
  logic                            aclk = 1'b0;
  logic                            aresetn = 1'b0;
  logic [7:0]                      s_axi_awaddr = 8'h00;
  logic                            s_axi_awvalid = 1'b0;
  logic                            s_axi_awready;
  logic [31:0]                     s_axi_wdata = 32'h0;
  logic [3:0]                      s_axi_wstrb = 4'h1;
  logic                            s_axi_wvalid = 1'b0;
  logic                            s_axi_wready;
  logic [1:0]                      s_axi_bresp;
  logic                            s_axi_bvalid;
  logic                            s_axi_bready = 1'b0;
  logic [7:0]                      s_axi_araddr = 8'h00;
  logic                            s_axi_arvalid = 1'b0;
  logic                            s_axi_arready;
  logic [31:0]                     s_axi_rdata;
  logic [1:0]                      s_axi_rresp;
  logic                            s_axi_rvalid;
  logic                            s_axi_rready = 1'b0;
  logic                            timer1_pwm = 1'b0;
  logic                            overtemp_pin = 1'b0;
  hbridge_pkg::gate_pair_type [1:0] gates_q;
  logic                            hv_driver_on_q;
  logic                            thermal_irq_q;
  logic [3:0]                      gate_bits;
  logic [3:0]                      pol_mirror = 4'h0;
  logic [1:0]                      last_resp;
  int                              overlap_count;
  int                              err_count = 0;
  int                              cmp_count = 0;
  int                              cyc = 0;

  assign gate_bits = gates_q;

  // Clock and timeout
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end

  hbridge_output_control i_hbridge_output_control (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer1_pwm(timer1_pwm),
    .overtemp_pin(overtemp_pin), .gates_q(gates_q),
    .hv_driver_on_q(hv_driver_on_q), .thermal_irq_q(thermal_irq_q));

  gate_load_model i_gate_load_model (
    .aclk(aclk), .gates(gates_q), .invert(pol_mirror),
    .hv_on(hv_driver_on_q), .overlap_count(overlap_count));

  // Comparison and closing report
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Register bus master
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready === 1'b1) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Driver power sequencing, guard set first and cleared first
  task automatic hv_on();
    axi_write(`HV_DRIVER_CONTROL_OFS, 8'h08);
    axi_write(`HV_DRIVER_CONTROL_OFS, 8'h18);
  endtask

  task automatic hv_off();
    axi_write(`HV_DRIVER_CONTROL_OFS, 8'h10);
    axi_write(`HV_DRIVER_CONTROL_OFS, 8'h00);
  endtask

  // Expected gate pair {top,bottom} through align, guard, polarity
  function automatic logic [1:0] expect_pair(logic [1:0] mode, logic pwm,
                                             logic [1:0] man,
                                             logic [1:0] pol);
    logic [1:0] p;
    case (mode)
      2'b00:   p = {pwm, ~pwm};
      2'b01:   p = {pwm, 1'b0};
      2'b10:   p = {1'b0, pwm};
      default: p = man;
    endcase
    if (p == 2'b11) p = 2'b00;
    return p ^ pol;
  endfunction

  // Drive the pwm and count edges until channel 1 top follows
  task automatic edge_time(input logic lvl, output int n);
    timer1_pwm <= lvl;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (gate_bits[3] !== lvl && n < 200);
  endtask

  task automatic t_regs();
    logic [7:0]  ofs [6] = '{`ALIGN_SELECT_OFS, `GATE_CONTROL_OFS,
      `DEADTIME_CONFIG_OFS, `OUTPUT_POLARITY_OFS, `HV_DRIVER_CONTROL_OFS,
      `THERMAL_IRQ_OFS};
    logic [7:0]  keep [5] = '{8'h0f, 8'h0f, 8'hff, 8'h0f, 8'h2b};
    logic [31:0] d;
    foreach (ofs[i]) begin
      axi_read(ofs[i], d);
      check("reset value", d, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      axi_write(ofs[i], (i == 4) ? 8'hef : 8'hff);
      check("write resp", {30'h0, last_resp}, 32'h0);
      axi_read(ofs[i], d);
      check("masked readback", d, {24'h0, keep[i]});
      axi_write(ofs[i], 8'h00);
    end
    // Write with byte lane 0 off must leave the register alone
    s_axi_wstrb <= 4'h0;
    axi_write(`ALIGN_SELECT_OFS, 8'h0f);
    s_axi_wstrb <= 4'h1;
    check("strobeless write resp", {30'h0, last_resp}, 32'h0);
    axi_read(`ALIGN_SELECT_OFS, d);
    check("strobeless write ignored", d, 32'h0);
    axi_read(8'h18, d);
    check("unmapped read data", d, 32'h0);
    check("unmapped read resp", {30'h0, last_resp}, 32'h2);
    axi_read(8'h02, d);
    check("misaligned read resp", {30'h0, last_resp}, 32'h2);
    axi_write(8'h1c, 8'hff);
    check("unmapped write resp", {30'h0, last_resp}, 32'h2);
    $display("Test registers done");
  endtask

  task automatic t_align();
    logic [1:0] m0, m1, g0, g1;
    logic [3:0] e;
    hv_on();
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 4; g++) begin
        for (int p = 0; p < 2; p++) begin
          m0 = 2'(m);
          m1 = 2'(3 - m);
          g0 = 2'(g);
          g1 = 2'(3 - g);
          axi_write(`ALIGN_SELECT_OFS, {4'h0, m1, m0});
          axi_write(`GATE_CONTROL_OFS, {4'h0, g1, g0});
          timer1_pwm <= p[0];
          repeat (4) @(posedge aclk);
          e = {expect_pair(m1, p[0], g1, 2'b00),
               expect_pair(m0, p[0], g0, 2'b00)};
          check("aligned gates", {28'h0, gate_bits}, {28'h0, e});
        end
      end
    end
    $display("Test align done");
  endtask

  task automatic t_polarity();
    axi_write(`ALIGN_SELECT_OFS, 8'h00);
    timer1_pwm <= 1'b1;
    for (int v = 0; v < 16; v += 5) begin
      hv_off();
      axi_write(`OUTPUT_POLARITY_OFS, 8'(v));
      pol_mirror = 4'(v);
      repeat (4) @(posedge aclk);
      check("gates driver off", {28'h0, gate_bits}, 32'h0);
      check("driver flag", {31'h0, hv_driver_on_q}, 32'h0);
      hv_on();
      repeat (4) @(posedge aclk);
      check("driver flag on", {31'h0, hv_driver_on_q}, 32'h1);
      check("polarity", {28'h0, gate_bits}, {28'h0, 4'ha ^ pol_mirror});
    end
    hv_off();
    axi_write(`OUTPUT_POLARITY_OFS, 8'h00);
    pol_mirror = 4'h0;
    hv_on();
    $display("Test polarity done");
  endtask

  task automatic t_deadtime();
    int   n;
    int   base;
    logic seen_high;
    int   cnt;
    edge_time(1'b0, n);
    edge_time(1'b1, n);
    check("bypass delay", 32'(n), 32'd3);
    for (int c = 0; c < 4; c++) begin
      // Slow dividers use counts inside the recommended window
      cnt = (c == 2) ? 18 : (c == 3) ? 9 : 5;
      axi_write(`DEADTIME_CONFIG_OFS, {c[1:0], 1'b1, 5'(cnt)});
      edge_time(1'b0, n);
      check("falling edge delay", 32'(n), 32'd3);
      repeat (60) @(posedge aclk);
      edge_time(1'b1, n);
      base = (cnt + 1) << c;
      check("dead-time window",
            {31'h0, n >= base - (1 << c) + 2 && n <= base + 3}, 32'h1);
    end
    // Pulse shorter than the dead-time must never reach the output
    axi_write(`DEADTIME_CONFIG_OFS, 8'h25);
    edge_time(1'b0, n);
    repeat (20) @(posedge aclk);
    timer1_pwm <= 1'b1;
    repeat (3) @(posedge aclk);
    timer1_pwm <= 1'b0;
    seen_high = 1'b0;
    repeat (20) begin
      @(posedge aclk);
      seen_high = seen_high | gate_bits[3];
    end
    check("short pulse hidden", {31'h0, seen_high}, 32'h0);
    edge_time(1'b1, n);
    check("count restarts", {31'h0, n >= 7 && n <= 9}, 32'h1);
    axi_write(`DEADTIME_CONFIG_OFS, 8'h00);
    $display("Test dead-time done");
  endtask

  task automatic t_thermal();
    logic [31:0] d;
    overtemp_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_read(`HV_DRIVER_CONTROL_OFS, d);
    check("overtemp flag", d & 32'h4, 32'h4);
    axi_read(`THERMAL_IRQ_OFS, d);
    check("irq flag masked", d, 32'h1);
    check("irq line masked", {31'h0, thermal_irq_q}, 32'h0);
    axi_write(`THERMAL_IRQ_OFS, 8'h02);
    repeat (3) @(posedge aclk);
    check("irq line", {31'h0, thermal_irq_q}, 32'h1);
    axi_write(`THERMAL_IRQ_OFS, 8'h03);
    repeat (3) @(posedge aclk);
    check("irq cleared", {31'h0, thermal_irq_q}, 32'h0);
    overtemp_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    axi_read(`HV_DRIVER_CONTROL_OFS, d);
    check("overtemp idle", d, 32'h18);
    hv_off();
    $display("Test thermal done");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_align();
    t_polarity();
    t_deadtime();
    t_thermal();
    check("overlap cycles", 32'(overlap_count), 32'h0);
    end_sim();
  end
endmodule
